// file: ltws_seq.sv
// List trigger-wait sequencer, top level with AHB-Lite register slave.
// Assumes one clock hclk, async active-low reset, trigger pin asynchronous.
//
// How it works
// - A wait step drives its own level at once on entry.
// - Wait-high with trigger already high and timeout set skips at once.
// - Wait-high entered low advances on rise or nonzero timeout, first wins.
// - Zero timeout: wait-high holds until the trigger goes high.
// - Trigger level accepted only after 0.4 ms stable; driver holds it that long.
// - Wait step without prior current or voltage entry posts -221.
// - Run with dwell count unequal to both voltage and current counts posts -226.
// - Falling-edge step needs a real high-to-low; low at entry must rise first.
// - Falling-edge step with timeout advances on fall or timeout, first wins.
// - Zero timeout: falling-edge step holds until a fall is seen.
// - Clearing the lists sets the fill pointer to zero.
// - Each voltage point bumps the pointer; query returns the pointer.
// - Point query while current entries exist posts -221.
// - Start angle up to 359.99, stop angle 0.01 to 360 accepted only.
// - Missing stop angle defaults to 360 degrees.
// - Sweep register reads back the stored start and stop angles.
// - Generate appends points to both voltage and dwell arrays.
// - Waves other than the level shape centred on zero, shifted by optional offset.
// - Generated points clamped to the voltage soft limits.
`timescale 1ns/10ps
`default_nettype none
module ltws_seq
  import ltws_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int TICK = TICK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger pin and output level
  input wire logic trig_in,
  output logic [15:0] out_level,
  output logic running
);
  typedef enum logic [3:0] {
    LT_IDLE = 4'b0001,
    LT_STEP = 4'b0010,
    LT_WAIT = 4'b0100,
    LT_DONE = 4'b1000
  } ltws_state_e;

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [15:0] volt_mem_r [DEPTH];
  logic [1:0] kind_mem_r [DEPTH];
  logic [15:0] dwell_mem_r [DEPTH];
  logic [4:0] vptr_r, dptr_r, cptr_r, step_r;
  logic [15:0] timeout_r, err_r, ang_start_r, ang_stop_r, limit_hi_r, limit_lo_r;
  logic [15:0] dwell_cnt_r, tmo_cnt_r;
  logic [31:0] tick_r, data_r;
  logic [4:0] query_r;
  ltws_state_e state_r;
  logic seen_high_r, trig_d_r;
  logic wr_pend_r;
  logic [2:0] shape_r;
  logic [7:0] addr_r;
  logic trig_lvl;
  logic gen_valid, gen_busy;
  logic [15:0] gen_value;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire take = hsel && hready && htrans[1];
  wire wr_cmd = wr_pend_r && addr_r == REG_CMD;
  wire [3:0] cmd = hwdata[3:0];
  wire idle = state_r == LT_IDLE && !gen_busy && !gen_valid;
  wire has_list = vptr_r != 5'h00 || cptr_r != 5'h00;
  wire list_full = vptr_r == 5'(DEPTH);
  wire is_wait = cmd == CMD_WAIT_HIGH || cmd == CMD_WAIT_FALL;
  wire do_clear = wr_cmd && cmd == CMD_CLEAR && idle;
  wire do_point = wr_cmd && idle && !list_full &&
    (cmd == CMD_VOLT || (is_wait && has_list));
  wire wait_bad = wr_cmd && idle && is_wait && !has_list;
  wire do_gen = wr_cmd && idle && cmd == CMD_GENERATE;
  wire do_query = wr_cmd && cmd == CMD_POINT_QUERY;
  wire do_run = wr_cmd && idle && cmd == CMD_RUN && vptr_r != 5'h00;
  wire lens_bad = vptr_r != dptr_r && cptr_r != dptr_r;
  wire [15:0] w_start = hwdata[15:0];
  wire [15:0] w_stop = (hwdata[31:16] == 16'h0000) ? ANG_FULL : hwdata[31:16];
  wire ang_ok = w_start <= ANG_START_MAX && w_stop >= ANG_STOP_MIN && w_stop <= ANG_FULL;
  wire gen_push = gen_valid && !list_full;

  // ----------------------------------------------------------------
  // Step execution terms
  // ----------------------------------------------------------------
  wire [1:0] cur_kind = kind_mem_r[step_r[3:0]];
  wire tmo_on = timeout_r != 16'h0000;
  wire tmo_hit = tmo_on && tmo_cnt_r >= timeout_r;
  wire fell = trig_d_r && !trig_lvl;
  wire high_go = trig_lvl || tmo_hit;
  wire fall_go = (fell && seen_high_r) || tmo_hit;
  wire skip_now = cur_kind == STEP_HIGH && trig_lvl && tmo_on;
  wire dwell_go = dwell_cnt_r >= dwell_mem_r[step_r[3:0]];
  wire advance = (state_r == LT_STEP && (skip_now || (cur_kind == STEP_LEVEL))) ||
    (state_r == LT_WAIT && ((cur_kind == STEP_HIGH) ? high_go :
      (cur_kind == STEP_FALL) ? fall_go : dwell_go));
  wire last_step = step_r == vptr_r - 5'h01;

  ltws_trig_filter #(.FILT(FILTER_CYC)) u_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .trig_pin(trig_in),
    .trig_level(trig_lvl)
  );

  ltws_wave_gen #(.NPTS(DEPTH / 2)) u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(do_gen),
    .shape(shape_r),
    .ampl(data_r[15:0]),
    .offs(data_r[31:16]),
    .ang_start(ang_start_r),
    .ang_stop(ang_stop_r),
    .lim_hi(limit_hi_r),
    .lim_lo(limit_lo_r),
    .pt_valid(gen_valid),
    .pt_value(gen_value),
    .busy(gen_busy)
  );

  // ----------------------------------------------------------------
  // Bus phase capture; zero wait states, always OKAY
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take) addr_r <= haddr[7:0];
    end
  end

  // Read mux on the address phase, registered into the data phase
  logic [31:0] rd_val;
  always_comb begin
    unique case (haddr[7:0])
      REG_DATA: rd_val = data_r;
      REG_TIMEOUT: rd_val = {16'h0000, timeout_r};
      REG_SWEEP: rd_val = {ang_stop_r, ang_start_r};
      REG_STATUS: rd_val = {24'h000000, state_r, 1'b0, gen_busy, trig_lvl, running};
      REG_COUNT: rd_val = {27'h0, query_r};
      REG_ERROR: rd_val = {16'h0000, err_r};
      REG_LEVEL: rd_val = {16'h0000, out_level};
      REG_LIMIT: rd_val = {limit_hi_r, limit_lo_r};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (take && !hwrite) ? rd_val : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= 32'h00000000;
      timeout_r <= 16'h0000;
      ang_start_r <= 16'h0000;
      ang_stop_r <= ANG_FULL;
      limit_hi_r <= 16'h7fff;
      limit_lo_r <= 16'h8000;
      shape_r <= SHP_SQUARE;
    end else if (wr_pend_r) begin
      if (addr_r == REG_DATA) data_r <= hwdata;
      if (do_gen) shape_r <= hwdata[6:4];
      if (addr_r == REG_TIMEOUT) timeout_r <= hwdata[15:0];
      if (addr_r == REG_LIMIT) {limit_hi_r, limit_lo_r} <= hwdata;
      if (addr_r == REG_SWEEP && ang_ok) begin
        ang_start_r <= w_start;
        ang_stop_r <= w_stop;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error register, latest error wins, cleared by writing it
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) err_r <= 16'h0000;
    else if (wait_bad || (do_query && cptr_r != 5'h00)) err_r <= ERR_CONFLICT;
    else if (do_run && lens_bad) err_r <= ERR_LENGTH;
    else if (wr_pend_r && addr_r == REG_SWEEP && !ang_ok) err_r <= ERR_RANGE;
    else if (wr_pend_r && addr_r == REG_ERROR) err_r <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Fill pointers and list storage
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vptr_r <= 5'h00;
      dptr_r <= 5'h00;
      cptr_r <= 5'h00;
      query_r <= 5'h00;
    end else begin
      if (do_clear) begin
        vptr_r <= 5'h00;
        dptr_r <= 5'h00;
        cptr_r <= 5'h00;
      end else begin
        if (do_point || gen_push) vptr_r <= vptr_r + 5'h01;
        if ((wr_cmd && idle && cmd == CMD_DWELL && dptr_r != 5'(DEPTH)) ||
            (gen_push && dptr_r != 5'(DEPTH))) dptr_r <= dptr_r + 5'h01;
        if (wr_cmd && idle && cmd == CMD_CURR && cptr_r != 5'(DEPTH)) cptr_r <= cptr_r + 5'h01;
      end
      if (do_query) query_r <= vptr_r;
    end
  end

  // Per-entry storage, written at the fill pointers
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        volt_mem_r[i] <= 16'h0000;
        kind_mem_r[i] <= STEP_LEVEL;
        dwell_mem_r[i] <= 16'h0000;
      end else begin
        if (do_point && vptr_r == 5'(i)) begin
          volt_mem_r[i] <= hwdata[31:16];
          kind_mem_r[i] <= (cmd == CMD_WAIT_HIGH) ? STEP_HIGH :
            (cmd == CMD_WAIT_FALL) ? STEP_FALL : STEP_LEVEL;
        end else if (gen_push && vptr_r == 5'(i)) begin
          volt_mem_r[i] <= gen_value;
          kind_mem_r[i] <= STEP_LEVEL;
        end
        if (gen_push && dptr_r == 5'(i)) dwell_mem_r[i] <= data_r[31:16];
        else if (wr_cmd && idle && cmd == CMD_DWELL && dptr_r == 5'(i))
          dwell_mem_r[i] <= hwdata[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Step state machine
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= LT_IDLE;
      step_r <= 5'h00;
      out_level <= 16'h0000;
      running <= 1'b0;
    end else begin
      unique case (state_r)
        LT_IDLE: if (do_run && !lens_bad) begin
          state_r <= LT_STEP;
          step_r <= 5'h00;
          running <= 1'b1;
        end
        LT_STEP: begin
          out_level <= volt_mem_r[step_r[3:0]];
          if (!advance) state_r <= LT_WAIT;
          else if (last_step) state_r <= LT_DONE;
          else step_r <= step_r + 5'h01;
        end
        LT_WAIT: if (advance) begin
          if (last_step) state_r <= LT_DONE;
          else begin
            step_r <= step_r + 5'h01;
            state_r <= LT_STEP;
          end
        end
        LT_DONE: begin
          state_r <= LT_IDLE;
          running <= 1'b0;
        end
        default: state_r <= LT_IDLE;
      endcase
    end
  end

  // Timeout, dwell and edge tracking, all restarted at step entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_r <= 32'h00000000;
      tmo_cnt_r <= 16'h0000;
      dwell_cnt_r <= 16'h0000;
      seen_high_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= trig_lvl;
      if (state_r != LT_WAIT) begin
        tick_r <= 32'h00000000;
        tmo_cnt_r <= 16'h0000;
        dwell_cnt_r <= 16'h0000;
        seen_high_r <= trig_lvl;
      end else begin
        if (trig_lvl) seen_high_r <= 1'b1;
        if (tick_r == 32'(TICK - 1)) begin
          tick_r <= 32'h00000000;
          if (tmo_cnt_r != 16'hffff) tmo_cnt_r <= tmo_cnt_r + 16'h0001;
          if (dwell_cnt_r != 16'hffff) dwell_cnt_r <= dwell_cnt_r + 16'h0001;
        end else tick_r <= tick_r + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  level_at_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == LT_STEP |=> out_level == $past(volt_mem_r[step_r[3:0]]))
    else $error("step level not driven on entry");
  skip_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == LT_STEP && cur_kind == STEP_HIGH && trig_lvl && tmo_on |=> state_r != LT_WAIT)
    else $error("wait-high step not skipped");
  hold_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == LT_WAIT && cur_kind == STEP_HIGH && !tmo_on && !trig_lvl |=> state_r == LT_WAIT)
    else $error("zero timeout wait-high left early");
  fall_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == LT_WAIT && cur_kind == STEP_FALL && !tmo_on && !fell |=> state_r == LT_WAIT)
    else $error("falling-edge step left without a fall");
  wait_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wait_bad |=> err_r == ERR_CONFLICT && $stable(vptr_r))
    else $error("wait without list not rejected");
  clear_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_clear |=> vptr_r == 5'h00)
    else $error("clear did not zero the pointer");
  query_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_query && cptr_r != 5'h00 |=> err_r == ERR_CONFLICT)
    else $error("query conflict not posted");
  tmo_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == LT_STEP |=> tmo_cnt_r == 16'h0000)
    else $error("timeout not cleared at step entry");
  len_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_run && lens_bad |=> err_r == ERR_LENGTH ##1 state_r == LT_IDLE)
    else $error("unbalanced lists not flagged");
  run_c: cover property (@(posedge hclk) disable iff (!hresetn) state_r == LT_DONE);
  tmo_c: cover property (@(posedge hclk) disable iff (!hresetn) state_r == LT_WAIT && tmo_hit);
  fall_c: cover property (@(posedge hclk) disable iff (!hresetn) state_r == LT_WAIT && fell);
  gen_c: cover property (@(posedge hclk) disable iff (!hresetn) gen_push);
endmodule : ltws_seq
`default_nettype wire

// file: ltws_pkg.sv
// Package for the list trigger-wait sequencer.
// Assumes a single 125 MHz clock domain and a 32-bit AHB-Lite register bus.
package ltws_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int FILTER_US_X10 = 4000; // 0.4 ms, in tenths of a microsecond
  localparam int FILTER_CYC = (FILTER_US_X10 * CLK_MHZ + 9) / 10;
  localparam int TICK_US = 1000; // Timeout unit: 1 ms
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_TIMEOUT = 8'h08;
  localparam logic [7:0] REG_SWEEP = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam logic [7:0] REG_ERROR = 8'h18;
  localparam logic [7:0] REG_LEVEL = 8'h1c;
  localparam logic [7:0] REG_LIMIT = 8'h20;

  // ----------------------------------------------------------------
  // Command codes written to REG_CMD
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_CLEAR = 4'h1;
  localparam logic [3:0] CMD_VOLT = 4'h2;
  localparam logic [3:0] CMD_CURR = 4'h3;
  localparam logic [3:0] CMD_DWELL = 4'h4;
  localparam logic [3:0] CMD_WAIT_HIGH = 4'h5;
  localparam logic [3:0] CMD_WAIT_FALL = 4'h6;
  localparam logic [3:0] CMD_GENERATE = 4'h7;
  localparam logic [3:0] CMD_POINT_QUERY = 4'h8;
  localparam logic [3:0] CMD_RUN = 4'h9;

  // Waveform shape codes, REG_CMD bits 6:4 with CMD_GENERATE
  localparam logic [2:0] SHP_SQUARE = 3'h0;
  localparam logic [2:0] SHP_RAMP_UP = 3'h1;
  localparam logic [2:0] SHP_RAMP_DN = 3'h2;
  localparam logic [2:0] SHP_TRIANGLE = 3'h3;
  localparam logic [2:0] SHP_SINE = 3'h4;
  localparam logic [2:0] SHP_LEVEL = 3'h5;

  // ----------------------------------------------------------------
  // Angles in hundredths of a degree, and error codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ANG_START_MAX = 16'd35999;
  localparam logic [15:0] ANG_STOP_MIN = 16'd1;
  localparam logic [15:0] ANG_FULL = 16'd36000;
  localparam logic [15:0] ERR_CONFLICT = 16'hff23; // -221
  localparam logic [15:0] ERR_LENGTH = 16'hff1e; // -226
  localparam logic [15:0] ERR_RANGE = 16'hff9c; // -100, bad angle

  // Step kinds stored beside each voltage point
  localparam logic [1:0] STEP_LEVEL = 2'h0;
  localparam logic [1:0] STEP_HIGH = 2'h1;
  localparam logic [1:0] STEP_FALL = 2'h2;

endpackage : ltws_pkg

// file: ltws_trig_filter.sv
// Trigger pin synchroniser and level filter.
// Assumes an asynchronous pin; output changes only after a stable level.
`timescale 1ns/10ps
`default_nettype none
module ltws_trig_filter
  import ltws_pkg::*;
#(
  parameter int FILT = FILTER_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin and filtered level
  input wire logic trig_pin,
  output logic trig_level
);
  logic s1_r, s2_r;
  logic [19:0] cnt_r;

  // Two-flop synchroniser, then a stability counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= 20'h00000;
      trig_level <= 1'b0;
    end else begin
      s1_r <= trig_pin;
      s2_r <= s1_r;
      if (s2_r == trig_level) cnt_r <= 20'h00000;
      else if (cnt_r >= 20'(FILT - 1)) begin
        trig_level <= s2_r;
        cnt_r <= 20'h00000;
      end else cnt_r <= cnt_r + 20'h00001;
    end
  end

  filt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(trig_level) |-> $past(s2_r) == trig_level)
    else $error("filtered level changed against the input");
endmodule : ltws_trig_filter
`default_nettype wire

// file: ltws_wave_gen.sv
// Waveform point generator for the voltage list.
// Assumes start pulses only while idle; emits one point a cycle.
`timescale 1ns/10ps
`default_nettype none
module ltws_wave_gen
  import ltws_pkg::*;
#(
  parameter int NPTS = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic start,
  input wire logic [2:0] shape,
  input wire logic [15:0] ampl,
  input wire logic [15:0] offs,
  input wire logic [15:0] ang_start,
  input wire logic [15:0] ang_stop,
  input wire logic [15:0] lim_hi,
  input wire logic [15:0] lim_lo,
  // Point stream
  output logic pt_valid,
  output logic [15:0] pt_value,
  output logic busy
);
  logic [4:0] idx_r;
  logic [15:0] ph;
  logic signed [17:0] half, tri_v, ramp_v, raw, cent;
  logic signed [17:0] sin_v;

  // Phase in hundredths of a degree across the angle window
  assign ph = 16'(32'(ang_start) + (32'(ang_stop - ang_start) * 32'(idx_r)) / NPTS);
  assign half = 18'($signed({2'b00, ampl}) >>> 1);
  assign ramp_v = 18'(-half + (($signed({2'b00, ampl}) * $signed({13'h0, idx_r})) / NPTS));
  assign tri_v = (ph < 16'd18000) ?
    18'(-half + ($signed({2'b00, ampl}) * $signed({2'b00, ph})) / 18000) :
    18'(half - ($signed({2'b00, ampl}) * $signed({2'b00, 16'(ph - 16'd18000)})) / 18000);
  // Sine by parabola, adequate for a coarse point series
  assign sin_v = (ph < 16'd18000) ?
    18'(($signed({2'b00, half[15:0]}) * 4 * $signed({2'b00, ph}) *
      $signed({2'b00, 16'(16'd18000 - ph)})) / 48'sd324000000) :
    18'(-($signed({2'b00, half[15:0]}) * 4 * $signed({2'b00, 16'(ph - 16'd18000)}) *
      $signed({2'b00, 16'(ANG_FULL - ph)})) / 48'sd324000000);

  // Shape select, all but the level shape centred on zero then shifted by the offset
  always_comb begin
    unique case (shape)
      SHP_SQUARE: raw = (idx_r < 5'(NPTS / 2)) ? half : -half;
      SHP_RAMP_UP: raw = ramp_v;
      SHP_RAMP_DN: raw = -ramp_v;
      SHP_TRIANGLE: raw = tri_v;
      SHP_SINE: raw = sin_v;
      default: raw = $signed({2'b00, ampl});
    endcase
    cent = (shape == SHP_LEVEL) ? raw : 18'(raw + $signed({{2{offs[15]}}, offs}));
  end

  // Index and clamped output point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 5'h00;
      busy <= 1'b0;
      pt_valid <= 1'b0;
      pt_value <= 16'h0000;
    end else begin
      pt_valid <= busy;
      if (cent > $signed({{2{lim_hi[15]}}, lim_hi})) pt_value <= lim_hi;
      else if (cent < $signed({{2{lim_lo[15]}}, lim_lo})) pt_value <= lim_lo;
      else pt_value <= cent[15:0];
      if (start && !busy) begin
        busy <= 1'b1;
        idx_r <= 5'h00;
      end else if (busy) begin
        if (idx_r == 5'(NPTS - 1) || shape == SHP_LEVEL) busy <= 1'b0;
        idx_r <= idx_r + 5'h01;
      end
    end
  end
endmodule : ltws_wave_gen
`default_nettype wire

// file: ltws_trig_src.sv
// Trigger instrument model for the sequencer bench.
// Assumes the bench requests levels; each level stands a filter time.
`timescale 1ns/10ps
`default_nettype none
module ltws_trig_src
  import ltws_pkg::*;
#(
  parameter int HOLD = FILTER_CYC + 8
) (
  // Clock and level request
  input wire logic hclk,
  input wire logic want,
  // Trigger pin
  output logic trig_in
);
  int hold_cnt = HOLD; // Idle low level has stood since before reset
  initial trig_in = 1'b0;
  // Follow the request only once the last level has stood long enough
  always @(posedge hclk) begin
    if (hold_cnt < HOLD) hold_cnt <= hold_cnt + 1;
    else if (want !== trig_in) begin
      trig_in <= want;
      hold_cnt <= 0;
    end
  end
endmodule : ltws_trig_src
`default_nettype wire

// file: tb_list_trigger_wait_sequencer.sv
// Bench for the list trigger-wait sequencer.
// Assumes a zero-wait AHB-Lite slave; trigger pin from ltws_trig_src.
`timescale 1ns/10ps
`default_nettype none
module tb_list_trigger_wait_sequencer import ltws_pkg::*; ;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, want = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [15:0] out_level;
  logic hreadyout, hresp, running, trig_in;
  int num_errors = 0, check_count = 0, q[$], n, k, m;
  ltws_seq #(.TICK(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
    .out_level(out_level), .running(running));
  ltws_trig_src src (.hclk(hclk), .want(want), .trig_in(trig_in));
  // Free-running bus clock
  initial forever #4 hclk = ~hclk;
  task end_of_test();
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // A used-up wait bound is a mismatch and ends the run
  task lim(input int b);
    if (k >= b) begin
      num_errors++;
      end_of_test();
    end
  endtask : lim
  // Bounded wait for the slave's ready
  task rdy();
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    lim(50);
  endtask : rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus
  task cmd(input logic [3:0] c, input logic [15:0] v);
    bus(1'b1, REG_CMD, {v, 12'h0, c});
  endtask : cmd
  task err(input logic [15:0] e);
    bus(1'b0, REG_ERROR, 32'h0);
    chk("error", {16'h0, e}, rd);
    bus(1'b1, REG_ERROR, 32'h0);
  endtask : err
  // Level point then wait-high step, both dwell 0, timeout 10 cycles
  task run_wait(input bit skip);
    logic [15:0] lvl;
    lvl = skip ? 16'h0333 : 16'h0222;
    cmd(CMD_CLEAR, 16'h0);
    cmd(CMD_VOLT, 16'h0011);
    cmd(CMD_WAIT_HIGH, lvl);
    cmd(CMD_DWELL, 16'h0);
    cmd(CMD_DWELL, 16'h0);
    cmd(CMD_RUN, 16'h0);
    for (k = 0; k < 40 && out_level !== lvl; k++) @(posedge hclk);
    lim(40);
    chk("level", {16'h0, lvl}, {16'h0, out_level});
    for (k = 0; k < 40 && running === 1'b1; k++) @(posedge hclk);
    lim(40);
    chk("running", 32'h0, {31'h0, running});
    chk("early", {31'h0, skip}, {31'h0, k < 4});
  endtask : run_wait
  // Main sequence
  initial begin
    k = $urandom(89311);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, REG_SWEEP, 32'h0);
    chk("sweep", {ANG_FULL, 16'h0}, rd);
    err(16'h0);
    cmd(CMD_CLEAR, 16'h0);
    cmd(CMD_WAIT_HIGH, 16'h0100);
    err(ERR_CONFLICT);
    n = $urandom_range(5, 2);
    for (int i = 0; i < n; i++) begin
      q.push_back($urandom);
      cmd(CMD_VOLT, 16'(q[i]));
    end
    cmd(CMD_POINT_QUERY, 16'h0);
    bus(1'b0, REG_COUNT, 32'h0);
    chk("count", q.size(), rd);
    q.delete();
    cmd(CMD_CLEAR, 16'h0);
    cmd(CMD_POINT_QUERY, 16'h0);
    bus(1'b0, REG_COUNT, 32'h0);
    chk("count", q.size(), rd);
    bus(1'b1, REG_SWEEP, {16'h0, ANG_FULL});
    err(ERR_RANGE);
    bus(1'b1, REG_SWEEP, 32'h000004d2);
    bus(1'b0, REG_SWEEP, 32'h0);
    chk("sweep", {ANG_FULL, 16'h04d2}, rd);
    bus(1'b1, REG_SWEEP, 32'h46502328);
    bus(1'b0, REG_SWEEP, 32'h0);
    chk("sweep", 32'h46502328, rd);
    cmd(CMD_CURR, 16'h0010);
    cmd(CMD_POINT_QUERY, 16'h0);
    err(ERR_CONFLICT);
    cmd(CMD_CLEAR, 16'h0);
    cmd(CMD_VOLT, 16'h0001);
    cmd(CMD_VOLT, 16'h0002);
    cmd(CMD_DWELL, 16'h0);
    cmd(CMD_RUN, 16'h0);
    repeat (3) @(posedge hclk);
    chk("running", 32'h0, {31'h0, running});
    err(ERR_LENGTH);
    // One generated level point, clamped to a random upper limit
    n = $urandom_range(32767, 1);
    m = $urandom_range(32767, 1);
    cmd(CMD_CLEAR, 16'h0);
    bus(1'b1, REG_LIMIT, {16'(m), 16'h8000});
    bus(1'b1, REG_DATA, {16'h0, 16'(n)});
    bus(1'b1, REG_CMD, {25'h0, SHP_LEVEL, CMD_GENERATE});
    cmd(CMD_POINT_QUERY, 16'h0);
    bus(1'b0, REG_COUNT, 32'h0);
    chk("count", 32'h1, rd);
    cmd(CMD_RUN, 16'h0);
    repeat (4) @(posedge hclk);
    chk("level", (n > m) ? m : n, {16'h0, out_level});
    bus(1'b1, REG_TIMEOUT, 32'h1);
    run_wait(1'b0);
    want <= 1'b1;
    for (k = 0; k < 100 && trig_in !== 1'b1; k++) @(posedge hclk);
    lim(100);
    repeat (FILTER_CYC + 8) @(posedge hclk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("trig", 32'h1, {31'h0, rd[1]});
    run_wait(1'b1);
    end_of_test();
  end
endmodule : tb_list_trigger_wait_sequencer
`default_nettype wire
